// file: hdl/pfl_defs.svh
`ifndef PFL_DEFS_SVH
`define PFL_DEFS_SVH
// ==========================================================
// Register byte offsets
`define PFL_OFF_CTRL       8'h00
`define PFL_OFF_FAULT      8'h04
`define PFL_OFF_INPUTS     8'h08
`define PFL_OFF_IRQ_STAT   8'h0C
`define PFL_OFF_IRQ_MASK   8'h10
// ==========================================================
// Reset values
`define PFL_CTRL_RST       2'h3
`define PFL_IRQ_MASK_RST   3'h0
// ==========================================================
// Field positions
`define PFL_CTRL_IND_EN    0
`define PFL_CTRL_WARN_EN   1
`define PFL_FAULT_LATCHED  8
`define PFL_IRQ_FAULT      0
`define PFL_IRQ_LOWBAT     1
`define PFL_IRQ_FLASH      2
// ==========================================================
// Fault code sources (upper nibble)
`define PFL_SRC_ADAPTER    4'h1
`define PFL_SRC_BATTERY    4'h2
`define PFL_SRC_RAIL_BASE  4'h4
// ==========================================================
// Timing
`define PFL_CLK_HZ         50000000
`define PFL_TICK_MS        500
`define PFL_TICK_CYC       ((`PFL_CLK_HZ / 1000) * `PFL_TICK_MS)
`define PFL_START_TICKS    3'h4
`define PFL_ONE_TICKS      3'h2
`define PFL_ZERO_TICKS     3'h1
`define PFL_GAP_TICKS      3'h1
`define PFL_CODE_BITS      4'h8
`define PFL_FLASH_PULSES   3'h3
`endif

// file: hdl/pfl_pkg.sv
package pfl_pkg;
  // Fault flags from the supervision comparators
  typedef struct packed {
    logic [10:0][5:0] rail;
    logic [5:0]       battery;
    logic [4:0]       adapter;
  } pfl_flags_t;

  // Supply state inputs
  typedef struct packed {
    logic adapter_present;
    logic on_battery;
    logic batt_low;
    logic quick_charge;
    logic batt_full;
    logic hibernated;
    logic power_switch;
  } pfl_pwr_t;

  // Bicolour indicator drive
  typedef struct packed {
    logic batt_orange;
    logic batt_blue;
    logic dc_orange;
    logic dc_blue;
  } pfl_led_t;

  typedef enum logic [1:0] {
    PFL_IDLE,
    PFL_START,
    PFL_BIT_ON,
    PFL_GAP
  } pfl_state_t;
endpackage

// file: hdl/pfl_top.sv
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
`include "pfl_defs.svh"
module pfl_top
  import pfl_pkg::*;
#(
  parameter int unsigned TICK_CYC = `PFL_TICK_CYC,
  parameter int unsigned ADDR_W   = 8
) (
  input  wire logic              clock,
  input  wire logic              arst_n,
  input  wire pfl_flags_t        fault_flags,
  input  wire pfl_pwr_t          pwr_state,
  output pfl_led_t               led,
  output logic                   irq,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  localparam int unsigned FW = $bits(pfl_flags_t);
  localparam int unsigned PW = $bits(pfl_pwr_t);
  localparam int unsigned TW = $clog2(TICK_CYC + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYC - 1);

  // Conditions each rail can report, rail 4h at bit group 0
  localparam logic [10:0][5:0] RAIL_VALID = {
    6'h1F,  // Eh aux 2.5 V
    6'h1F,  // Dh 1.25 V
    6'h1F,  // Ch graphics core
    6'h0F,  // Bh graphics 2.5 V
    6'h1F,  // Ah 3.3 V
    6'h1F,  // 9h 5 V
    6'h1F,  // 8h 1.2 V
    6'h0F,  // 7h processor core
    6'h3F,  // 6h cpu side 1.8 V
    6'h3F,  // 5h cpu side 1.5 V
    6'h21   // 4h standby 3.3 V
  };

  // ==========================================================
  // Input synchronisers
  logic [FW-1:0] flt_s1_r, flt_s2_r, flt_s3_r, flt_r;
  logic [PW-1:0] pwr_s1_r, pwr_s2_r, pwr_s3_r, pwr_r;
  pfl_flags_t    flt;
  pfl_pwr_t      pwr;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flt_s1_r <= '0;
      flt_s2_r <= '0;
      flt_s3_r <= '0;
      pwr_s1_r <= '0;
      pwr_s2_r <= '0;
      pwr_s3_r <= '0;
    end else begin
      flt_s1_r <= fault_flags;
      flt_s2_r <= flt_s1_r;
      flt_s3_r <= flt_s2_r;
      pwr_s1_r <= pwr_state;
      pwr_s2_r <= pwr_s1_r;
      pwr_s3_r <= pwr_s2_r;
    end
  end

  // A bit counts once the last two stages agree
  genvar gi;
  generate
    for (gi = 0; gi < FW + PW; gi++) begin : g_filt
      if (gi < FW) begin : g_f
        always_ff @(posedge clock or negedge arst_n) begin
          if (!arst_n) begin
            flt_r[gi] <= 1'b0;
          end else if (flt_s2_r[gi] == flt_s3_r[gi]) begin
            flt_r[gi] <= flt_s2_r[gi];
          end
        end
      end else begin : g_p
        always_ff @(posedge clock or negedge arst_n) begin
          if (!arst_n) begin
            pwr_r[gi-FW] <= 1'b0;
          end else if (pwr_s2_r[gi-FW] == pwr_s3_r[gi-FW]) begin
            pwr_r[gi-FW] <= pwr_s2_r[gi-FW];
          end
        end
      end
    end
  endgenerate

  assign flt = pfl_flags_t'(flt_r);
  assign pwr = pfl_pwr_t'(pwr_r);

  // ==========================================================
  // Fault encoder, lowest code wins when several arrive together
  logic       any_fault;
  logic [7:0] code_nxt;

  always_comb begin
    any_fault = 1'b0;
    code_nxt  = 8'h00;
    for (int r = 10; r >= 0; r--) begin
      for (int c = 5; c >= 0; c--) begin
        if (flt.rail[r][c] && RAIL_VALID[r][c]) begin
          any_fault = 1'b1;
          code_nxt  = {4'(`PFL_SRC_RAIL_BASE + 4'(r)), 4'(c)};
        end
      end
    end
    for (int c = 5; c >= 0; c--) begin
      if (flt.battery[c]) begin
        any_fault = 1'b1;
        code_nxt  = {`PFL_SRC_BATTERY, 4'(c)};
      end
    end
    for (int c = 4; c >= 0; c--) begin
      if (flt.adapter[c]) begin
        any_fault = 1'b1;
        code_nxt  = {`PFL_SRC_ADAPTER, 4'(c)};
      end
    end
  end

  // First fault is held until power goes away
  logic       latched_r;
  logic [7:0] code_r;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      latched_r <= 1'b0;
      code_r    <= 8'h00;
    end else if (any_fault && !latched_r) begin
      latched_r <= 1'b1;
      code_r    <= code_nxt;
    end
  end

  // ==========================================================
  // Half-second tick
  logic [TW-1:0] pre_r;
  logic          tick_r;
  logic          restart;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pre_r  <= '0;
      tick_r <= 1'b0;
    end else if (restart || pre_r == TICK_LAST) begin
      pre_r  <= '0;
      tick_r <= !restart;
    end else begin
      pre_r  <= pre_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  // ==========================================================
  // Code sequencer
  pfl_state_t state_r;
  logic [2:0] left_r;
  logic [3:0] bit_r;

  // Restart the prescaler so the first start period is full length plus one clock
  assign restart = (state_r == PFL_IDLE) && latched_r;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= PFL_IDLE;
      left_r  <= 3'h0;
      bit_r   <= 4'h0;
    end else begin
      case (state_r)
        PFL_IDLE: begin
          if (latched_r) begin
            state_r <= PFL_START;
            left_r  <= `PFL_START_TICKS;
            bit_r   <= 4'h0;
          end
        end
        PFL_START: begin
          if (tick_r) begin
            if (left_r == 3'h1) begin
              state_r <= PFL_BIT_ON;
              left_r  <= code_r[0] ? `PFL_ONE_TICKS : `PFL_ZERO_TICKS;
              bit_r   <= 4'h0;
            end else begin
              left_r <= left_r - 3'h1;
            end
          end
        end
        PFL_BIT_ON: begin
          if (tick_r) begin
            if (left_r != 3'h1) begin
              left_r <= left_r - 3'h1;
            end else if (bit_r == `PFL_CODE_BITS - 4'h1) begin
              // Last bit runs straight into the next dark start period
              state_r <= PFL_START;
              left_r  <= `PFL_START_TICKS;
            end else begin
              state_r <= PFL_GAP;
              left_r  <= `PFL_GAP_TICKS;
            end
          end
        end
        PFL_GAP: begin
          if (tick_r) begin
            if (left_r == 3'h1) begin
              state_r <= PFL_BIT_ON;
              bit_r   <= bit_r + 4'h1;
              left_r  <= code_r[3'(bit_r + 4'h1)] ? `PFL_ONE_TICKS : `PFL_ZERO_TICKS;
            end else begin
              left_r <= left_r - 3'h1;
            end
          end
        end
        default: begin
          state_r <= PFL_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Battery warnings
  logic       blink_r;
  logic       sw_d_r;
  logic [2:0] flash_r;
  logic       flash_ph_r;
  logic       warn;
  logic       flash_go;

  assign warn     = pwr.on_battery && pwr.batt_low && !pwr.hibernated;
  assign flash_go = pwr.power_switch && !sw_d_r && pwr.batt_low && pwr.hibernated;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      blink_r    <= 1'b0;
      sw_d_r     <= 1'b0;
      flash_r    <= 3'h0;
      flash_ph_r <= 1'b0;
    end else begin
      sw_d_r <= pwr.power_switch;
      if (!warn) begin
        blink_r <= 1'b0;
      end else if (tick_r) begin
        blink_r <= !blink_r;
      end
      if (flash_go) begin
        flash_r    <= `PFL_FLASH_PULSES + 3'h1;
        flash_ph_r <= 1'b0;  // Dark until the next tick so every pulse is a whole tick
      end else if (tick_r && flash_r != 3'h0) begin
        flash_ph_r <= !flash_ph_r;
        if (!flash_ph_r) begin
          flash_r <= flash_r - 3'h1;
        end
      end
    end
  end

  // ==========================================================
  // Indicator drive
  logic [1:0] ctrl_r;
  logic       dc_lit;

  assign dc_lit = (state_r == PFL_BIT_ON);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      led <= '0;
    end else if (!ctrl_r[`PFL_CTRL_IND_EN]) begin
      led <= '0;
    end else begin
      led.dc_orange <= latched_r && dc_lit;
      led.dc_blue   <= !latched_r && pwr.adapter_present;
      if (flash_r != 3'h0) begin
        led.batt_orange <= flash_ph_r;
        led.batt_blue   <= 1'b0;
      end else if (pwr.quick_charge) begin
        led.batt_orange <= 1'b1;
        led.batt_blue   <= 1'b0;
      end else if (pwr.batt_full && pwr.adapter_present) begin
        led.batt_orange <= 1'b0;
        led.batt_blue   <= 1'b1;
      end else begin
        led.batt_orange <= warn && ctrl_r[`PFL_CTRL_WARN_EN] && blink_r;
        led.batt_blue   <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Interrupt status, set wins over a clearing write
  logic [2:0] irq_stat_r;
  logic [2:0] irq_mask_r;
  logic [2:0] irq_evt;
  logic [2:0] irq_clr;
  logic       warn_d_r;

  assign irq_evt = {flash_go, warn && !warn_d_r, any_fault && !latched_r};

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      warn_d_r   <= 1'b0;
      irq_stat_r <= 3'h0;
      irq        <= 1'b0;
    end else begin
      warn_d_r   <= warn;
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt;
      irq        <= |(((irq_stat_r & ~irq_clr) | irq_evt) & irq_mask_r);
    end
  end

  // ==========================================================
  // AXI4-Lite write side, address and data in either order
  logic              aw_held_r, w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              do_wr;
  logic              wr_hit;

  assign do_wr  = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_hit = awaddr_r == ADDR_W'(`PFL_OFF_CTRL) || awaddr_r == ADDR_W'(`PFL_OFF_IRQ_STAT)
               || awaddr_r == ADDR_W'(`PFL_OFF_IRQ_MASK) || awaddr_r == ADDR_W'(`PFL_OFF_FAULT)
               || awaddr_r == ADDR_W'(`PFL_OFF_INPUTS);
  assign irq_clr = (do_wr && awaddr_r == ADDR_W'(`PFL_OFF_IRQ_STAT) && wstrb_r[0]) ? wdata_r[2:0] : 3'h0;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= '0;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held_r && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= {s_axi_awaddr[ADDR_W-1:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_held_r     <= 1'b0;
        w_held_r      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r     <= `PFL_CTRL_RST;
      irq_mask_r <= `PFL_IRQ_MASK_RST;
    end else if (do_wr && wstrb_r[0]) begin
      if (awaddr_r == ADDR_W'(`PFL_OFF_CTRL)) begin
        ctrl_r <= wdata_r[1:0];
      end
      if (awaddr_r == ADDR_W'(`PFL_OFF_IRQ_MASK)) begin
        irq_mask_r <= wdata_r[2:0];
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read side
  logic [31:0] rd_word;
  logic        rd_hit;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case ({s_axi_araddr[ADDR_W-1:2], 2'h0})
      ADDR_W'(`PFL_OFF_CTRL):     rd_word = {30'h0, ctrl_r};
      ADDR_W'(`PFL_OFF_FAULT):    rd_word = {23'h0, latched_r, code_r};
      ADDR_W'(`PFL_OFF_INPUTS):   rd_word = {24'h0, state_r == PFL_BIT_ON, pwr_r};
      ADDR_W'(`PFL_OFF_IRQ_STAT): rd_word = {29'h0, irq_stat_r};
      ADDR_W'(`PFL_OFF_IRQ_MASK): rd_word = {29'h0, irq_mask_r};
      default:                    rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_arready <= !s_axi_rvalid;
    end
  end

endmodule

// file: tb/pfl_top_checker.sv
`timescale 1ns/10ps
module pfl_checker
  import pfl_pkg::*;
#(
  parameter int unsigned TICK_CYC = 8
) (
  input wire logic        clock,
  input wire logic        arst_n,
  input wire pfl_led_t    led,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  // ==========================================
  // Lamp run lengths
  logic [31:0] lit_r;
  logic [31:0] dark_r;
  logic        seen_r;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lit_r  <= '0;
      dark_r <= '0;
      seen_r <= 1'b0;
    end else begin
      lit_r  <= led.dc_orange ? lit_r + 32'h1 : '0;
      dark_r <= led.dc_orange ? '0 : dark_r + 32'h1;
      seen_r <= seen_r | led.dc_orange;
    end
  end

  // ==========================================
  // Properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid) else $error("write response late");
  a_read_answer: assert property (rd_taken |=> s_axi_rvalid) else $error("read response late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  a_dc_colours: assert property (!(led.dc_orange && led.dc_blue)) else $error("dc lamp both colours");
  a_batt_colours: assert property (!(led.batt_orange && led.batt_blue)) else $error("battery lamp both colours");
  a_lit_length: assert property ($fell(led.dc_orange) |-> lit_r == TICK_CYC || lit_r == 2 * TICK_CYC)
    else $error("code pulse length wrong");
  a_dark_length: assert property ($rose(led.dc_orange) && seen_r |-> dark_r == TICK_CYC || dark_r == 4 * TICK_CYC)
    else $error("dark period length wrong");
endmodule

bind pfl_top pfl_checker #(.TICK_CYC(TICK_CYC)) u_chk (
  .clock(clock), .arst_n(arst_n), .led(led), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// file: tb/pfl_lamp_reader.sv
`timescale 1ns/10ps
// ==========================================
// Person reading the dc lamp: decodes blink frames
module pfl_lamp_reader
  import pfl_pkg::*;
#(
  parameter int unsigned TICK_CYC = 8
) (
  input wire logic       clock,
  input wire logic       arst_n,
  input wire pfl_led_t   led,
  output logic [7:0]     code,
  output logic           code_valid
);
  logic [31:0] run_r;
  logic        lit_q;
  logic [7:0]  sh_r;
  logic [3:0]  nbit_r;
  logic        one_bit;

  assign one_bit = run_r > (TICK_CYC * 3) / 2;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      run_r      <= '0;
      lit_q      <= 1'b0;
      sh_r       <= '0;
      nbit_r     <= 4'h8;
      code       <= '0;
      code_valid <= 1'b0;
    end else begin
      code_valid <= 1'b0;
      lit_q      <= led.dc_orange;
      if (led.dc_orange != lit_q) begin
        run_r <= 32'h1;
        if (lit_q && nbit_r < 4'h8) begin
          sh_r   <= {one_bit, sh_r[7:1]};
          nbit_r <= nbit_r + 4'h1;
          if (nbit_r == 4'h7) begin
            code       <= {one_bit, sh_r[7:1]};
            code_valid <= 1'b1;
          end
        end else if (!lit_q && run_r >= 3 * TICK_CYC) begin
          nbit_r <= 4'h0;
        end
      end else begin
        run_r <= run_r + 32'h1;
      end
    end
  end
endmodule

// file: tb/test_pfl_top.sv
`timescale 1ns/10ps
module test_pfl_top
  import pfl_pkg::*;
;
  localparam int unsigned TICK = 8;
  logic        clock;
  logic        arst_n;
  pfl_flags_t  fault_flags;
  pfl_pwr_t    pwr_state;
  pfl_led_t    led;
  logic        irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  seen_code;
  logic        seen_valid;
  int          failures = 0;
  int          samples_checked = 0;
  logic [31:0] d;
  logic [1:0]  r;
  int          on;
  logic [7:0]  codes [28] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25,
    8'h40, 8'h45, 8'h50, 8'h54, 8'h55, 8'h60, 8'h65, 8'h70, 8'h73, 8'h84, 8'h90, 8'h94, 8'hA4, 8'hB3,
    8'hC4, 8'hD4, 8'hE4};
  logic [6:0]  pw [4] = '{7'h08, 7'h44, 7'h40, 7'h00};
  logic [3:0]  lw [4] = '{4'h8, 4'h5, 4'h1, 4'h0};

  pfl_top #(.TICK_CYC(TICK), .ADDR_W(8)) DUT (
    .clock(clock), .arst_n(arst_n), .fault_flags(fault_flags), .pwr_state(pwr_state), .led(led), .irq(irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );

  pfl_lamp_reader #(.TICK_CYC(TICK)) u_reader (
    .clock(clock), .arst_n(arst_n), .led(led), .code(seen_code), .code_valid(seen_valid)
  );

  initial clock = 1'b0;
  always #10 clock = ~clock;

  // ==========================================
  // Reporting
  task automatic results();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic give_up();
    failures++;
    $display("BAD t=%0t wait ran out", $time);
    results();
  endtask

  // ==========================================
  // Bus cycles; rready raised a cycle late to exercise a held read response
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    int n;
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n == 1) s_axi_bready <= 1'b1;
      if (s_axi_bvalid && s_axi_bready) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (n == 100) give_up();
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    int n;
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n == 1) s_axi_rready <= 1'b1;
      if (s_axi_rvalid && s_axi_rready) begin
        v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n == 100) give_up();
  endtask

  task automatic set_pwr(input logic [6:0] p);
    pwr_state <= pfl_pwr_t'(p);
    repeat (8) @(posedge clock);
  endtask

  task automatic count_batt(input int cyc, output int lit);
    lit = 0;
    repeat (cyc) begin
      @(posedge clock);
      lit += led.batt_orange;
    end
  endtask

  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
  endtask

  function automatic pfl_flags_t flag_for(input logic [7:0] c);
    pfl_flags_t f;
    int idx;
    f = '0;
    if (c[7:4] == 4'h1) idx = int'(c[3:0]);
    else if (c[7:4] == 4'h2) idx = 5 + int'(c[3:0]);
    else idx = 11 + 6 * (int'(c[7:4]) - 4) + int'(c[3:0]);
    f[idx] = 1'b1;
    return f;
  endfunction

  task automatic wait_code();
    int n;
    for (n = 0; n < TICK * 80; n++) begin
      @(posedge clock);
      if (seen_valid) break;
    end
    if (n == TICK * 80) give_up();
  endtask

  // ==========================================
  // Main sequence
  initial begin
    arst_n = 1'b0;
    fault_flags = '0;
    pwr_state = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    do_reset();

    axi_read(8'h00, d, r);
    chk_word(d, 32'h3, "ctrl reset");
    axi_read(8'h10, d, r);
    chk_word(d, 32'h0, "mask reset");
    axi_read(8'h14, d, r);
    chk_word({r, d[29:0]}, 32'h80000000, "unmapped read");
    axi_write(8'h14, 32'h1, r);
    chk_word(32'(r), 32'h2, "unmapped write");
    axi_write(8'h10, 32'h7, r);
    axi_read(8'h10, d, r);
    chk_word(d, 32'h7, "mask rw");
    $display("registers done");

    for (int i = 0; i < 4; i++) begin
      set_pwr(pw[i]);
      chk_word(32'(led), 32'(lw[i]), "steady lamps");
    end
    set_pwr(7'h40);
    axi_read(8'h08, d, r);
    chk_word(d, 32'h40, "inputs view");
    axi_write(8'h00, 32'h0, r);
    repeat (2) @(posedge clock);
    chk_word(32'(led), 32'h0, "lamps disabled");
    axi_write(8'h00, 32'h3, r);
    $display("steady lamps done");

    set_pwr(7'h30);
    count_batt(16 * TICK, on);
    chk_word(32'(on), 32'(8 * TICK), "low battery duty");
    chk_word(32'(irq), 32'h1, "irq on warning");
    axi_read(8'h0C, d, r);
    chk_word(d, 32'h2, "warning status");
    axi_write(8'h0C, 32'h2, r);
    repeat (4) @(posedge clock);
    chk_word(32'(irq), 32'h0, "irq cleared");
    $display("low battery done");

    set_pwr(7'h32);
    pwr_state <= pfl_pwr_t'(7'h33);
    count_batt(10 * TICK, on);
    chk_word(32'(on), 32'(3 * TICK), "flash pulses");
    axi_read(8'h0C, d, r);
    chk_word(d, 32'h4, "flash status");
    $display("flash done");

    // One latched code per power cycle, so reset between codes
    foreach (codes[i]) begin
      fault_flags <= '0;
      do_reset();
      set_pwr(7'h40);
      fault_flags <= flag_for(codes[i]);
      for (int k = 0; k < 2; k++) begin
        wait_code();
        chk_word(32'(seen_code), 32'(codes[i]), "blinked code");
      end
      chk_word(32'(led.dc_blue), 32'h0, "blue off on fault");
      axi_read(8'h04, d, r);
      chk_word(d, 32'h100 | 32'(codes[i]), "latched code");
    end
    fault_flags <= '0;
    do_reset();
    fault_flags <= flag_for(8'h41);
    repeat (40) @(posedge clock);
    axi_read(8'h04, d, r);
    chk_word(d, 32'h0, "no standby code 41");
    $display("fault codes done");
    results();
  end
endmodule
